// ===== verilog/phy_mii_carrier_latency.sv
`timescale 1ns/100ps
`include "phy_mii_defines.svh"
module phy_mii_carrier_latency (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       mii_clk,
  // Line side: inputs asynchronous to every clock here, outputs registered on mclk.
  input  wire logic [3:0] line_receive_pair_pn,
  input  wire logic       line_rx_stream,
  input  wire logic       line_rx_code_err,
  input  wire logic       line_receive_pair,
  input  wire logic       mode_fast,
  input  wire logic       mode_fibre,
  input  wire logic       duplex_full,
  output logic [3:0]      line_transmit_pair,
  output logic            line_tx_en,
  output logic            line_tx_err,
  // MAC side, on mii_clk.
  input  wire logic [3:0] txd,
  input  wire logic       tx_en,
  input  wire logic       tx_er,
  output logic [3:0]      rxd,
  output logic            rx_dv,
  output logic            rx_er,
  output logic            crs,
  output logic            col
);

  // ==========================================================
  // Declarations
  // ==========================================================
  logic [`PIN_W-1:0]        pin_meta_ff;
  logic [`PIN_W-1:0]        pin_sync_ff;
  logic [3:0]               rx_nib;
  logic                     rx_stream_s;
  logic                     rx_err_s;
  logic                     rx_active_s;
  logic                     fast_s;
  logic                     fibre_s;
  logic                     full_s;
  phy_mii_pkg::line_mode_t  mode;
  logic                     txen_meta_ff;
  logic                     txen_sync_ff;
  logic [`TRK_COUNT-1:0]    trk_in;
  logic [`TRK_COUNT-1:0]    trk_out_ff;
  logic [`LAT_W-1:0]        rise_lim [`TRK_COUNT];
  logic [`LAT_W-1:0]        fall_lim [`TRK_COUNT];
  logic [`LAT_W-1:0]        trk_cnt_ff [`TRK_COUNT];
  logic                     release_q_ff;
  logic                     crs_core_ff;
  logic                     col_core_ff;
  logic                     crs_meta_ff;
  logic                     col_meta_ff;
  logic                     rel_meta_ff;
  logic                     rel_sync_ff;
  logic                     rx_lost_ff;
  logic                     nxt_rx_lost;
  logic                     rx_wr_valid;
  logic                     rx_wr_ready;
  phy_mii_pkg::mii_word_t   rx_wr_data;
  logic                     rx_rd_valid;
  phy_mii_pkg::mii_word_t   rx_rd_data;
  logic                     rx_pop;
  logic                     tx_lost_ff;
  logic                     nxt_tx_lost;
  logic                     tx_wr_ready;
  phy_mii_pkg::mii_word_t   tx_wr_data;
  logic                     tx_rd_valid;
  phy_mii_pkg::mii_word_t   tx_rd_data;
  logic                     tx_pop;

  // ==========================================================
  // Pin synchronisers on mclk
  // ==========================================================
  // Every line pin and strap passes two flops before anything reads it.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_ff <= '0;
      pin_sync_ff <= '0;
    end else begin
      pin_meta_ff <= {line_receive_pair_pn, line_rx_stream, line_rx_code_err,
                      line_receive_pair, mode_fast, mode_fibre, duplex_full};
      pin_sync_ff <= pin_meta_ff;
    end
  end

  assign rx_nib      = pin_sync_ff[9:6];
  assign rx_stream_s = pin_sync_ff[5];
  assign rx_err_s    = pin_sync_ff[4];
  assign rx_active_s = pin_sync_ff[3];
  assign fast_s      = pin_sync_ff[2];
  assign fibre_s     = pin_sync_ff[1];
  assign full_s      = pin_sync_ff[0];

  // Fibre is only meaningful at the fast rate; the slow rate is copper only.
  always_comb begin
    if (!fast_s) begin
      mode = phy_mii_pkg::MODE_SLOW;
    end else if (fibre_s) begin
      mode = phy_mii_pkg::MODE_FIBRE_FAST;
    end else begin
      mode = phy_mii_pkg::MODE_COPPER_FAST;
    end
  end

  // Transmit enable is a level from the MII domain, so two flops carry it over.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      txen_meta_ff <= 1'b0;
      txen_sync_ff <= 1'b0;
    end else begin
      txen_meta_ff <= tx_en;
      txen_sync_ff <= txen_meta_ff;
    end
  end

  // ==========================================================
  // Latency tables per mode
  // ==========================================================
  // Each tracker takes its longest printed time in whole cycles, rounded down; where that rounds to zero the one-cycle floor makes the edge late.
  always_comb begin
    unique case (mode)
      phy_mii_pkg::MODE_COPPER_FAST: begin
        rise_lim[`TRK_CARRIER] = `LAT_W'(`CYC_MAX(`J_CRS_FAST_T10, `BT_FAST_NS));
        fall_lim[`TRK_CARRIER] = `LAT_W'(`CYC_MAX(`T_CRS_TX_T10, `BT_FAST_NS));
        rise_lim[`TRK_COL]     = `LAT_W'(`CYC_MAX(`J_COL_TX_T10, `BT_FAST_NS));
        fall_lim[`TRK_COL]     = `LAT_W'(`CYC_MAX(`T_COL_TX_T10, `BT_FAST_NS));
        rise_lim[`TRK_TXCRS]   = `LAT_W'(`CYC_MAX(`TXEN_CRS_TX_T10, `BT_FAST_NS));
        fall_lim[`TRK_TXCRS]   = `LAT_W'(`CYC_MAX(`TXOFF_CRS_TX_T10, `BT_FAST_NS));
        rise_lim[`TRK_LINE]    = `LAT_W'(`CYC_MAX(`TX_LAT_TX_T10, `BT_FAST_NS));
        fall_lim[`TRK_LINE]    = `LAT_W'(`CYC_MAX(`TX_LAT_TX_T10, `BT_FAST_NS));
        rise_lim[`TRK_RELEASE] = `LAT_W'(`CYC_MAX(`CRS_DATA_FAST_T10, `BT_FAST_NS));
        fall_lim[`TRK_RELEASE] = `LAT_W'(1);
      end
      phy_mii_pkg::MODE_FIBRE_FAST: begin
        rise_lim[`TRK_CARRIER] = `LAT_W'(`CYC_MAX(`J_CRS_FAST_T10, `BT_FAST_NS));
        fall_lim[`TRK_CARRIER] = `LAT_W'(`CYC_MAX(`T_CRS_FX_T10, `BT_FAST_NS));
        rise_lim[`TRK_COL]     = `LAT_W'(`CYC_MAX(`J_COL_FX_T10, `BT_FAST_NS));
        fall_lim[`TRK_COL]     = `LAT_W'(`CYC_MAX(`T_COL_FX_T10, `BT_FAST_NS));
        rise_lim[`TRK_TXCRS]   = `LAT_W'(`CYC_MAX(`TXEN_CRS_FX_T10, `BT_FAST_NS));
        fall_lim[`TRK_TXCRS]   = `LAT_W'(`CYC_MAX(`TXOFF_CRS_FX_T10, `BT_FAST_NS));
        rise_lim[`TRK_LINE]    = `LAT_W'(`CYC_MAX(`TX_LAT_FX_T10, `BT_FAST_NS));
        fall_lim[`TRK_LINE]    = `LAT_W'(`CYC_MAX(`TX_LAT_FX_T10, `BT_FAST_NS));
        rise_lim[`TRK_RELEASE] = `LAT_W'(`CYC_MAX(`CRS_DATA_FAST_T10, `BT_FAST_NS));
        fall_lim[`TRK_RELEASE] = `LAT_W'(1);
      end
      default: begin
        // The spare code and the slow rate both land here, at 100 ns per bit time.
        rise_lim[`TRK_CARRIER] = `LAT_W'(`CYC_MAX(`ACT_CRS_SLOW_T10, `BT_SLOW_NS));
        fall_lim[`TRK_CARRIER] = `LAT_W'(`CYC_MAX(`QUIET_CRS_SLOW_T10, `BT_SLOW_NS));
        rise_lim[`TRK_COL]     = `LAT_W'(`CYC_MAX(`ACT_COL_SLOW_T10, `BT_SLOW_NS));
        fall_lim[`TRK_COL]     = `LAT_W'(`CYC_MAX(`QUIET_COL_SLOW_T10, `BT_SLOW_NS));
        rise_lim[`TRK_TXCRS]   = `LAT_W'(`CYC_MAX(`TXEN_CRS_SLOW_T10, `BT_SLOW_NS));
        fall_lim[`TRK_TXCRS]   = `LAT_W'(`CYC_MAX(`TXOFF_CRS_SLOW_T10, `BT_SLOW_NS));
        rise_lim[`TRK_LINE]    = `LAT_W'(`CYC_MAX(`TX_LAT_SLOW_T10, `BT_SLOW_NS));
        fall_lim[`TRK_LINE]    = `LAT_W'(`CYC_MAX(`TX_LAT_SLOW_T10, `BT_SLOW_NS));
        rise_lim[`TRK_RELEASE] = `LAT_W'(`CYC_MAX(`CRS_DATA_SLOW_T10, `BT_SLOW_NS));
        fall_lim[`TRK_RELEASE] = `LAT_W'(`CYC_MAX(`DATA_CRS_SLOW_T10, `BT_SLOW_NS));
      end
    endcase
  end

  // ==========================================================
  // Tracker inputs
  // ==========================================================
  // At the fast rate the stream flag spans J to T; at the slow rate activity does.
  assign trk_in[`TRK_CARRIER] = fast_s ? rx_stream_s : rx_active_s;
  // Collision needs both directions busy and half duplex.
  assign trk_in[`TRK_COL]     = trk_in[`TRK_CARRIER] & txen_sync_ff & ~full_s;
  assign trk_in[`TRK_TXCRS]   = txen_sync_ff;
  // Waiting nibbles hold the line gate open, so a burst shorter than the latency still leaves.
  assign trk_in[`TRK_LINE]    = txen_sync_ff | tx_rd_valid;
  assign trk_in[`TRK_RELEASE] = trk_out_ff[`TRK_CARRIER];

  // ==========================================================
  // Latency trackers
  // ==========================================================
  // Each output follows its input after the rise or fall count; a glitch shorter
  // than the count restarts it and never shows at the output.
  for (genvar g = 0; g < `TRK_COUNT; g++) begin : g_trk
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        trk_cnt_ff[g] <= '0;
        trk_out_ff[g] <= 1'b0;
      end else if (trk_in[g] == trk_out_ff[g]) begin
        trk_cnt_ff[g] <= '0;
      end else if (trk_cnt_ff[g] >= (trk_in[g] ? rise_lim[g] : fall_lim[g]) - `LAT_W'(1)) begin
        trk_cnt_ff[g] <= '0;
        trk_out_ff[g] <= trk_in[g];
      end else begin
        trk_cnt_ff[g] <= trk_cnt_ff[g] + `LAT_W'(1);
      end
    end
  end

  // ==========================================================
  // Carrier and collision levels
  // ==========================================================
  // Carrier is held one cycle past the data release so that it drops after the data.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      release_q_ff <= 1'b0;
      crs_core_ff  <= 1'b0;
      col_core_ff  <= 1'b0;
    end else begin
      release_q_ff <= trk_out_ff[`TRK_RELEASE];
      crs_core_ff  <= trk_out_ff[`TRK_CARRIER] | trk_out_ff[`TRK_RELEASE] |
                      release_q_ff | trk_out_ff[`TRK_TXCRS];
      col_core_ff  <= trk_out_ff[`TRK_COL] & ~full_s;
    end
  end

  // ==========================================================
  // Receive data path, line side
  // ==========================================================
  // The line cannot be stalled, so a nibble refused by a full FIFO is dropped and
  // the next nibble that gets in carries the error flag instead.
  // Nibbles before the data release are not stored: four words cannot absorb that wait.
  // A loss at the end of a frame is not carried into the next one.
  assign rx_wr_valid = trk_in[`TRK_CARRIER] & trk_out_ff[`TRK_RELEASE];
  assign rx_wr_data  = {rx_err_s | rx_lost_ff, rx_nib};
  assign nxt_rx_lost = rx_wr_valid & ~rx_wr_ready;

  // Loss flag: set for the cycle after a refused nibble, cleared by any cycle without a refusal.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_lost_ff <= 1'b0;
    end else begin
      rx_lost_ff <= nxt_rx_lost;
    end
  end

  cdc_fifo #(
    .WIDTH (`WORD_W),
    .DEPTH (`FIFO_DEPTH)
  ) u_rx_fifo (
    .wr_clk   (mclk),
    .wr_rst_n (rst_n),
    .wr_valid (rx_wr_valid),
    .wr_ready (rx_wr_ready),
    .wr_data  (rx_wr_data),
    .rd_clk   (mii_clk),
    .rd_rst_n (rst_n),
    .rd_valid (rx_rd_valid),
    .rd_ready (rel_sync_ff),
    .rd_data  (rx_rd_data)
  );

  // ==========================================================
  // MII side, on mii_clk
  // ==========================================================
  // Release, carrier and collision are levels and cross on two flops each.
  always_ff @(posedge mii_clk or negedge rst_n) begin
    if (!rst_n) begin
      rel_meta_ff <= 1'b0;
      rel_sync_ff <= 1'b0;
      crs_meta_ff <= 1'b0;
      crs         <= 1'b0;
      col_meta_ff <= 1'b0;
      col         <= 1'b0;
    end else begin
      rel_meta_ff <= trk_out_ff[`TRK_RELEASE];
      rel_sync_ff <= rel_meta_ff;
      crs_meta_ff <= crs_core_ff;
      crs         <= crs_meta_ff;
      col_meta_ff <= col_core_ff;
      col         <= col_meta_ff;
    end
  end

  assign rx_pop = rx_rd_valid & rel_sync_ff;

  // Receive outputs change on the MII clock edge; idle shows zeros.
  always_ff @(posedge mii_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxd   <= 4'h0;
      rx_dv <= 1'b0;
      rx_er <= 1'b0;
    end else begin
      rxd   <= rx_pop ? rx_rd_data[3:0] : 4'h0;
      rx_dv <= rx_pop;
      rx_er <= rx_pop & rx_rd_data[4];
    end
  end

  // Transmit nibbles are sampled on the MII clock; a refused nibble marks the next
  // one of the same frame, and the mark dies with transmit enable.
  assign tx_wr_data  = {tx_er | tx_lost_ff, txd};
  assign nxt_tx_lost = tx_en & ~tx_wr_ready;

  // Loss flag: set for the cycle after a refused nibble, cleared by any cycle without a refusal.
  always_ff @(posedge mii_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_lost_ff <= 1'b0;
    end else begin
      tx_lost_ff <= nxt_tx_lost;
    end
  end

  cdc_fifo #(
    .WIDTH (`WORD_W),
    .DEPTH (`FIFO_DEPTH)
  ) u_tx_fifo (
    .wr_clk   (mii_clk),
    .wr_rst_n (rst_n),
    .wr_valid (tx_en),
    .wr_ready (tx_wr_ready),
    .wr_data  (tx_wr_data),
    .rd_clk   (mclk),
    .rd_rst_n (rst_n),
    .rd_valid (tx_rd_valid),
    .rd_ready (trk_out_ff[`TRK_LINE]),
    .rd_data  (tx_rd_data)
  );

  // ==========================================================
  // Line transmit output
  // ==========================================================
  // The FIFO drains only once the transmit latency has run out after enable.
  assign tx_pop = tx_rd_valid & trk_out_ff[`TRK_LINE];

  // Line outputs are registered and idle at zero.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      line_transmit_pair <= 4'h0;
      line_tx_en         <= 1'b0;
      line_tx_err        <= 1'b0;
    end else begin
      line_transmit_pair <= tx_pop ? tx_rd_data[3:0] : 4'h0;
      line_tx_en         <= tx_pop;
      line_tx_err        <= tx_pop & tx_rd_data[4];
    end
  end

endmodule

// ===== include/phy_mii_defines.svh
// What this block does
// - Receive nibble, valid, error change on MII clock.
// - Transmit nibble, enable, error sampled on MII clock.
// - Fast modes: data starts 3-5 BT after carrier; the release tracker here waits one mclk cycle, 10 BT.
// - Fast modes: carrier 12-16 BT after J.
// - Carrier drops after T: copper 10-17, fibre 16-22.
// - Collision after J: copper 16-22, fibre 10-15.
// - Collision drops after T: copper 17-20, fibre 14-18.
// - Transmit enable to carrier: copper 20-24, fibre 17-20.
// - Enable drop to carrier drop: 24-28, 22-24.
// - Enable to line output: 5.3-5.7 or 5-5.3; the line tracker here waits one mclk cycle, 10 BT.
// - Slow mode line-to-data latency 4.2-6.6 BT.
// - Slow mode: data 5-32 BT after carrier.
// - Slow mode: carrier drops 0.3-0.5 BT after data; the release tracker here waits one mclk cycle, 1 BT.
// - Slow mode: carrier 2-28 BT after activity.
// - Slow mode: carrier drops 6-10 BT after quiet.
// - Slow mode: collision 1-31 BT after activity.
// - Slow mode: collision drops 5-10 BT after quiet.
// - Bit time is 10 ns fast, 100 ns slow.
`ifndef PHY_MII_DEFINES_SVH
`define PHY_MII_DEFINES_SVH

// ==========================================================
// Clock and bit times in nanoseconds
// ==========================================================
`define MCLK_NS     100
`define BT_FAST_NS  10
`define BT_SLOW_NS  100

// Longest time in tenths of a bit time to mclk cycles, rounded down, never below one.
`define CYC_MAX(t10, bt) \
  ((((t10) * (bt)) / (10 * `MCLK_NS)) < 1 ? 1 : (((t10) * (bt)) / (10 * `MCLK_NS)))

// ==========================================================
// Longest latencies in tenths of a bit time
// ==========================================================
`define CRS_DATA_FAST_T10   50
`define J_CRS_FAST_T10      160
`define T_CRS_TX_T10        170
`define T_CRS_FX_T10        220
`define J_COL_TX_T10        220
`define J_COL_FX_T10        150
`define T_COL_TX_T10        200
`define T_COL_FX_T10        180
`define TXEN_CRS_TX_T10     240
`define TXEN_CRS_FX_T10     200
`define TXOFF_CRS_TX_T10    280
`define TXOFF_CRS_FX_T10    240
`define TX_LAT_TX_T10       57
`define TX_LAT_FX_T10       53
`define CRS_DATA_SLOW_T10   320
`define DATA_CRS_SLOW_T10   5
`define ACT_CRS_SLOW_T10    280
`define QUIET_CRS_SLOW_T10  100
`define ACT_COL_SLOW_T10    310
`define QUIET_COL_SLOW_T10  100
`define TXEN_CRS_SLOW_T10   20
`define TXOFF_CRS_SLOW_T10  10
`define TX_LAT_SLOW_T10     725

// ==========================================================
// Latency trackers and widths
// ==========================================================
`define TRK_CARRIER  0
`define TRK_COL      1
`define TRK_TXCRS    2
`define TRK_LINE     3
`define TRK_RELEASE  4
`define TRK_COUNT    5
`define LAT_W        7
`define FIFO_DEPTH   4
`define WORD_W       5
`define PIN_W        10

`endif

// ===== include/phy_mii_pkg.sv
package phy_mii_pkg;

  // ==========================================================
  // Line modes
  // ==========================================================
  typedef enum logic [1:0] {
    MODE_COPPER_FAST = 2'b00,
    MODE_FIBRE_FAST  = 2'b01,
    MODE_SLOW        = 2'b10
  } line_mode_t;

  // Nibble plus its error flag, error in the top bit.
  typedef logic [4:0] mii_word_t;

endpackage

// ===== verilog/cdc_fifo.sv
`timescale 1ns/100ps
module cdc_fifo #(
  parameter int WIDTH = 5,
  parameter int DEPTH = 4
) (
  input  wire logic             wr_clk,
  input  wire logic             wr_rst_n,
  input  wire logic             wr_valid,
  output logic                  wr_ready,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic             rd_clk,
  input  wire logic             rd_rst_n,
  output logic                  rd_valid,
  input  wire logic             rd_ready,
  output logic [WIDTH-1:0]      rd_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wbin_ff;
  logic [AW:0]      wgray_ff;
  logic [AW:0]      rbin_ff;
  logic [AW:0]      rgray_ff;
  logic [AW:0]      rg_meta_ff;
  logic [AW:0]      rg_sync_ff;
  logic [AW:0]      wg_meta_ff;
  logic [AW:0]      wg_sync_ff;
  logic [AW:0]      nxt_wbin;
  logic [AW:0]      nxt_rbin;
  logic             push;
  logic             pop;

  // Full compares against the read pointer seen through two flops, so it may linger late.
  assign wr_ready = (wgray_ff != {~rg_sync_ff[AW:AW-1], rg_sync_ff[AW-2:0]});
  assign rd_valid = (rgray_ff != wg_sync_ff);
  assign push     = wr_valid & wr_ready;
  assign pop      = rd_valid & rd_ready;
  assign nxt_wbin = wbin_ff + (AW+1)'(push);
  assign nxt_rbin = rbin_ff + (AW+1)'(pop);
  assign rd_data  = mem[rbin_ff[AW-1:0]];

  // Storage has no reset; only words behind the write pointer are ever read.
  always_ff @(posedge wr_clk) begin
    if (push) begin
      mem[wbin_ff[AW-1:0]] <= wr_data;
    end
  end

  // Write pointer in binary and gray.
  always_ff @(posedge wr_clk or negedge wr_rst_n) begin
    if (!wr_rst_n) begin
      wbin_ff  <= '0;
      wgray_ff <= '0;
    end else begin
      wbin_ff  <= nxt_wbin;
      wgray_ff <= nxt_wbin ^ (nxt_wbin >> 1);
    end
  end

  // Read pointer crossing into the write side.
  always_ff @(posedge wr_clk or negedge wr_rst_n) begin
    if (!wr_rst_n) begin
      rg_meta_ff <= '0;
      rg_sync_ff <= '0;
    end else begin
      rg_meta_ff <= rgray_ff;
      rg_sync_ff <= rg_meta_ff;
    end
  end

  // Read pointer in binary and gray.
  always_ff @(posedge rd_clk or negedge rd_rst_n) begin
    if (!rd_rst_n) begin
      rbin_ff  <= '0;
      rgray_ff <= '0;
    end else begin
      rbin_ff  <= nxt_rbin;
      rgray_ff <= nxt_rbin ^ (nxt_rbin >> 1);
    end
  end

  // Write pointer crossing into the read side.
  always_ff @(posedge rd_clk or negedge rd_rst_n) begin
    if (!rd_rst_n) begin
      wg_meta_ff <= '0;
      wg_sync_ff <= '0;
    end else begin
      wg_meta_ff <= wgray_ff;
      wg_sync_ff <= wg_meta_ff;
    end
  end

endmodule

// ===== verification/phy_mii_chk_sva.sv
`timescale 1ns/100ps
// ==========================================================
// Pin-level latency checks
// ==========================================================
module phy_mii_chk (
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic       mii_clk,
  input wire logic       line_rx_stream,
  input wire logic       line_receive_pair,
  input wire logic       mode_fast,
  input wire logic       duplex_full,
  input wire logic       line_tx_en,
  input wire logic       tx_en,
  input wire logic [3:0] rxd,
  input wire logic       rx_dv,
  input wire logic       crs,
  input wire logic       col
);
  logic       busy;
  logic       overlap;
  logic [5:0] quiet_ff;
  logic [5:0] act_ff;
  logic [5:0] coll_ff;
  // Run lengths, since slow-mode limits are too long for a repetition.
  assign busy    = tx_en | line_rx_stream | line_receive_pair;
  assign overlap = tx_en & ~duplex_full & (mode_fast ? line_rx_stream : line_receive_pair);
  // Wrapping is harmless: the watched level still holds when a count comes round again.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      quiet_ff <= 6'h00;
      act_ff   <= 6'h00;
      coll_ff  <= 6'h00;
    end else begin
      quiet_ff <= busy ? 6'h00 : quiet_ff + 6'h01;
      act_ff   <= (mode_fast | ~line_receive_pair) ? 6'h00 : act_ff + 6'h01;
      coll_ff  <= overlap ? coll_ff + 6'h01 : 6'h00;
    end
  end
  sequence s_rx_held;
    (mode_fast && line_rx_stream)[*8];
  endsequence
  sequence s_tx_held;
    tx_en[*8];
  endsequence
  property p_rx_fast; @(posedge mclk) disable iff (!rst_n) s_rx_held |-> crs; endproperty
  a_rx_fast: assert property (p_rx_fast) else $error("crs late after stream");
  property p_rx_slow; @(posedge mclk) disable iff (!rst_n) act_ff == 6'h24 |-> crs; endproperty
  a_rx_slow: assert property (p_rx_slow) else $error("crs late after activity");
  property p_quiet; @(posedge mclk) disable iff (!rst_n) quiet_ff == 6'h14 |-> !crs && !col; endproperty
  a_quiet: assert property (p_quiet) else $error("crs or col stuck");
  property p_col; @(posedge mclk) disable iff (!rst_n) coll_ff == 6'h28 |-> col; endproperty
  a_col: assert property (p_col) else $error("col late");
  property p_tx_crs; @(posedge mii_clk) disable iff (!rst_n) s_tx_held |-> ##[0:16] crs; endproperty
  a_tx_crs: assert property (p_tx_crs) else $error("crs late after tx_en");
  property p_tx_line;
    @(posedge mii_clk) disable iff (!rst_n) $rose(tx_en) && mode_fast |-> ##[1:16] line_tx_en;
  endproperty
  a_tx_line: assert property (p_tx_line) else $error("line output late");
  property p_rx_idle; @(posedge mii_clk) disable iff (!rst_n) !rx_dv |-> rxd == 4'h0; endproperty
  a_rx_idle: assert property (p_rx_idle) else $error("rxd not idle");
  property p_slow_dv; @(posedge mii_clk) disable iff (!rst_n) !mode_fast && rx_dv |-> crs; endproperty
  a_slow_dv: assert property (p_slow_dv) else $error("data without carrier");
endmodule
bind phy_mii_carrier_latency phy_mii_chk u_chk (.mclk, .rst_n, .mii_clk, .line_rx_stream,
  .line_receive_pair, .mode_fast, .duplex_full, .line_tx_en, .tx_en, .rxd, .rx_dv, .crs, .col);

// ===== verification/mac_model.sv
`timescale 1ns/100ps
// ==========================================================
// MAC stand-in on the link clock
// ==========================================================
module mac_model (
  input  wire logic       mii_clk,
  input  wire logic       rst_n,
  input  wire logic       go,
  input  wire logic       clr,
  input  wire logic [7:0] len,
  input  wire logic [3:0] rxd,
  input  wire logic       rx_dv,
  input  wire logic       rx_er,
  output logic [3:0]      txd,
  output logic            tx_en,
  output logic            tx_er,
  output logic [3:0]      rx_last,
  output logic            rx_bad
);
  logic [7:0] left_ff;
  logic       go_ff;
  logic [3:0] seq_ff;
  // Sends len counting nibbles on a rise of go; idle txd flips so stale data never passes.
  always_ff @(posedge mii_clk or negedge rst_n) begin
    if (!rst_n) begin
      left_ff <= 8'h00;
      go_ff   <= 1'b0;
      seq_ff  <= 4'h0;
      txd     <= 4'h0;
      tx_en   <= 1'b0;
      tx_er   <= 1'b0;
    end else begin
      go_ff   <= go;
      left_ff <= (go && !go_ff) ? len : left_ff - {7'h00, left_ff != 8'h00};
      tx_en   <= left_ff != 8'h00;
      txd     <= (left_ff != 8'h00) ? seq_ff : ~txd;
      seq_ff  <= seq_ff + {3'h0, left_ff != 8'h00};
    end
  end
  // Takes receive signals on the rising link edge only while data is valid.
  always_ff @(posedge mii_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_last <= 4'h0;
      rx_bad  <= 1'b0;
    end else if (clr || rx_dv) begin
      rx_last <= clr ? 4'h0 : rxd;
      rx_bad  <= !clr && (rx_bad || rx_er);
    end
  end
endmodule

// ===== verification/phy_mii_carrier_latency_tb.sv
`timescale 1ns/100ps
// ==========================================================
// Bench for the carrier latency block
// ==========================================================
module phy_mii_carrier_latency_tb;
  logic       mclk = 1'b0;
  logic       mii_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [3:0] pn = 4'h0;
  logic       stream = 1'b0;
  logic       code_err = 1'b0;
  logic       act = 1'b0;
  logic       fast = 1'b1;
  logic       fibre = 1'b0;
  logic       dup = 1'b0;
  logic       go = 1'b0;
  logic       clr = 1'b0;
  logic [7:0] len = 8'h00;
  logic [3:0] line_nib, txd, rxd, last;
  logic       line_en, line_err, tx_en, tx_er, rx_dv, rx_er, crs, col, bad, ln_err;
  logic [3:0] ln_q[$];
  int         failures = 0;
  int         checks = 0;
  int         cyc = 0;
  int         seq = 0;
  phy_mii_carrier_latency uut (.mclk(mclk), .rst_n(rst_n), .mii_clk(mii_clk),
    .line_receive_pair_pn(pn), .line_rx_stream(stream), .line_rx_code_err(code_err),
    .line_receive_pair(act), .mode_fast(fast), .mode_fibre(fibre), .duplex_full(dup),
    .line_transmit_pair(line_nib), .line_tx_en(line_en), .line_tx_err(line_err),
    .txd(txd), .tx_en(tx_en), .tx_er(tx_er), .rxd(rxd), .rx_dv(rx_dv), .rx_er(rx_er),
    .crs(crs), .col(col));
  mac_model mac (.mii_clk(mii_clk), .rst_n(rst_n), .go(go), .clr(clr), .len(len), .rxd(rxd),
    .rx_dv(rx_dv), .rx_er(rx_er), .txd(txd), .tx_en(tx_en), .tx_er(tx_er), .rx_last(last),
    .rx_bad(bad));
  // Two free clocks; the link clock starts off phase and never lines up.
  initial begin
    forever #50 mclk = ~mclk;
  end
  initial begin
    #7;
    forever #24 mii_clk = ~mii_clk;
  end
  // Gathers line nibbles and cuts a hang short.
  always @(posedge mclk) begin
    cyc++;
    if (line_en === 1'b1) ln_q.push_back(line_nib);
    if (line_err === 1'b1) ln_err = 1'b1;
    if (cyc == 30000) begin
      failures++;
      end_sim();
    end
  end
  task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // Mode 0 copper, 1 fibre, 2 slow; changed only while the line is idle.
  task automatic set_mode(input int m);
    fast  <= (m != 2);
    fibre <= (m == 1);
    clr   <= 1'b1;
    ln_q.delete();
    ln_err = 1'b0;
    tick(30);
    clr <= 1'b0;
    tick(2);
  endtask
  // One nibble value received, then a coding fault, then quiet.
  task automatic rx_case(input int m);
    set_mode(m);
    pn     <= 4'h5;
    stream <= (m != 2);
    act    <= (m == 2);
    tick(m == 2 ? 80 : 12);
    chk("crs", 8'(crs), 8'h01);
    chk("rxd", 8'(last), 8'h05);
    chk("rx_er", 8'(bad), 8'h00);
    code_err <= 1'b1;
    tick(6);
    stream   <= 1'b0;
    act      <= 1'b0;
    code_err <= 1'b0;
    tick(20);
    chk("crs", 8'(crs), 8'h00);
    if (m != 2) chk("rx_er", 8'(bad), 8'h01);
  endtask
  // A short burst must arrive whole and in order; a long one overruns the buffer.
  task automatic tx_case(input int m, input int n);
    set_mode(m);
    len <= 8'(n);
    go  <= 1'b1;
    tick(2);
    go <= 1'b0;
    tick(110);
    if (n < 4) begin
      chk("count", 8'(ln_q.size()), 8'(n));
      for (int i = 0; i < n; i++) begin
        chk("nibble", 8'(ln_q[i]), 8'((seq + i) % 16));
      end
    end
    chk("line_err", 8'(ln_err), 8'(n > 4));
    chk("crs", 8'(crs), 8'h00);
    seq += n;
  endtask
  // Transmit overlapped by receive: collision only in half duplex.
  task automatic col_case(input int m, input logic full);
    set_mode(m);
    dup <= full;
    len <= 8'hc8;
    go  <= 1'b1;
    tick(10);
    go     <= 1'b0;
    stream <= (m != 2);
    act    <= (m == 2);
    tick(50);
    chk("col", 8'(col), 8'(!full));
    stream <= 1'b0;
    act    <= 1'b0;
    tick(60);
    chk("col", 8'(col), 8'h00);
    dup <= 1'b0;
    seq += 200;
  endtask
  task automatic end_sim();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    tick(3);
    rst_n <= 1'b1;
    for (int m = 0; m < 3; m++) begin
      rx_case(m);
      tx_case(m, 3);
      col_case(m, 1'b0);
    end
    tx_case(0, 15);
    col_case(1, 1'b1);
    end_sim();
  end
endmodule
